// file: verilog/iplr_pkg.sv
package iplr_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [3:0] IPLR_IDX_SYS    = 4'h2;
    localparam logic [3:0] IPLR_IDX_PA     = 4'h3;
    localparam logic [3:0] IPLR_IDX_PB     = 4'h4;
    localparam logic [3:0] IPLR_IDX_PC     = 4'h5;

    localparam int IPLR_NUM_SRC = 28;
    localparam int IPLR_ADDR_W  = 6;

    localparam logic [15:0] IPLR_RESET_VAL = 16'h0000;

    // Writable bit masks; everything else is reserved and reads zero.
    localparam logic [15:0] IPLR_MASK_SYS  = 16'h0FCF;
    localparam logic [15:0] IPLR_MASK_PA   = 16'hFFFC;
    localparam logic [15:0] IPLR_MASK_PB   = 16'hFC3F;
    localparam logic [15:0] IPLR_MASK_PC   = 16'hFF3F;

    // Field encodings.
    localparam logic [1:0] IPLR_ENC_OFF  = 2'h0;
    localparam logic [1:0] IPLR_ENC_LVL0 = 2'h1;
    localparam logic [1:0] IPLR_ENC_LVL1 = 2'h2;
    localparam logic [1:0] IPLR_ENC_LVL2 = 2'h3;

    // Decoded levels passed to arbitration.
    localparam logic [1:0] IPLR_LEVEL_0 = 2'h0;
    localparam logic [1:0] IPLR_LEVEL_1 = 2'h1;
    localparam logic [1:0] IPLR_LEVEL_2 = 2'h2;

    // Field base positions.
    localparam int IPLR_POS_FLASH_ERR  = 10;
    localparam int IPLR_POS_PLL_UNLOCK = 8;
    localparam int IPLR_POS_LOW_VOLT   = 6;
    localparam int IPLR_POS_EXT_B      = 2;
    localparam int IPLR_POS_EXT_A      = 0;
    localparam int IPLR_POS_PORT_D     = 14;
    localparam int IPLR_POS_PORT_E     = 12;
    localparam int IPLR_POS_PORT_F     = 10;
    localparam int IPLR_POS_CAN_MSGBUF = 8;
    localparam int IPLR_POS_CAN_WAKEUP = 6;
    localparam int IPLR_POS_CAN_ERROR  = 4;
    localparam int IPLR_POS_CAN_BUSOFF = 2;
    localparam int IPLR_POS_SPI0_RX    = 14;
    localparam int IPLR_POS_SPI1_TX    = 12;
    localparam int IPLR_POS_SPI1_RX    = 10;
    localparam int IPLR_POS_PORT_A     = 4;
    localparam int IPLR_POS_PORT_B     = 2;
    localparam int IPLR_POS_PORT_C     = 0;
    localparam int IPLR_POS_DEC1_INDEX = 14;
    localparam int IPLR_POS_DEC1_HOME  = 12;
    localparam int IPLR_POS_SER1_RX    = 10;
    localparam int IPLR_POS_SER1_RXERR = 8;
    localparam int IPLR_POS_SER1_IDLE  = 4;
    localparam int IPLR_POS_SER1_TX    = 2;
    localparam int IPLR_POS_SPI0_TX    = 0;

    // Decoded view of one source field.
    typedef struct packed {
        logic       enabled;
        logic [1:0] level;
    } iplr_level_t;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic                   cyc;
        logic                   stb;
        logic                   we;
        logic [3:0]             sel;
        logic [IPLR_ADDR_W-1:0] adr;
        logic [31:0]            dat;
    } iplr_wb_req_t;

endpackage : iplr_pkg

// file: verilog/iplr_decode.sv
module iplr_decode
    import iplr_pkg::*;
(
    input  wire logic [1:0]  field_i,
    input  wire logic        request_i,
    output iplr_level_t      level_o,
    output logic             request_o
);

    always_comb begin
        level_o.enabled = 1'b1;
        level_o.level   = IPLR_LEVEL_0;
        case (field_i)
            IPLR_ENC_OFF: begin
                level_o.enabled = 1'b0;
            end
            IPLR_ENC_LVL0: begin
                level_o.level = IPLR_LEVEL_0;
            end
            IPLR_ENC_LVL1: begin
                level_o.level = IPLR_LEVEL_1;
            end
            IPLR_ENC_LVL2: begin
                level_o.level = IPLR_LEVEL_2;
            end
            default: begin
                level_o.enabled = 1'b0;
            end
        endcase
    end

    assign request_o = request_i & level_o.enabled;

endmodule : iplr_decode

// file: verilog/iplr_regs.sv
// Operation
// - Each two-bit field means 00 off, 01 level 0, 10 level 1, 11 level 2.
// - No encoding can give these sources a level above 2.
// - Every field reads 00 after reset so every source starts disabled.
// - Reserved bits read zero and ignore writes.
// - System register holds PLL unlock in 9:8 and low voltage in 7:6.
// - System register reserves 5:4, external B in 3:2 and A in 1:0.
// - Peripheral register A holds ports D, E, F in 15:14, 13:12, 11:10.
// - Register A holds CAN msgbuf 9:8, wakeup 7:6, error 5:4, busoff 3:2.
// - Register B holds SPI0 rx 15:14, SPI1 tx 13:12, SPI1 rx 11:10.
// - Register B holds ports A, B, C in 5:4, 3:2, 1:0.
// - Register C holds decoder 1 index 15:14 and home or watchdog 13:12.
// - Register C holds serial 1 rx full 11:10 and rx error 9:8.
// - Register C holds serial 1 idle 5:4, tx empty 3:2, SPI0 tx 1:0.
// - System register also holds the flash error level in 11:10.
//
// Decided for this implementation: the Wishbone interface to the registers.
module iplr_regs
    import iplr_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [IPLR_ADDR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic [IPLR_NUM_SRC-1:0] src_req_i,
    output logic      [IPLR_NUM_SRC-1:0] src_req_o,
    output logic      [IPLR_NUM_SRC-1:0] src_enabled_o,
    output logic      [2*IPLR_NUM_SRC-1:0] src_level_o
);

    logic [15:0]  system_events_priority_q;
    logic [15:0]  periph_priority_a_q;
    logic [15:0]  periph_priority_b_q;
    logic [15:0]  periph_priority_c_q;
    logic         ack_q;
    logic [31:0]  rdata_q;
    logic         access;
    logic [3:0]   index;
    logic         aligned;
    logic [15:0]  lane_mask;
    logic [15:0]  rd_mux;
    logic [2*IPLR_NUM_SRC-1:0] fields;
    iplr_wb_req_t req;

    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we  = wb_we_i;
    assign req.sel = wb_sel_i;
    assign req.adr = wb_adr_i;
    assign req.dat = wb_dat_i;

    assign access    = req.cyc & req.stb & ~ack_q;
    assign index     = req.adr[IPLR_ADDR_W-1:2];
    assign aligned   = (req.adr[1:0] == 2'h0);
    assign lane_mask = {{8{req.sel[1]}}, {8{req.sel[0]}}};

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wr,
                                          input logic [15:0] lanes,
                                          input logic [15:0] keep);
        logic [15:0] upd;
        upd = (wr & lanes) | (old & ~lanes);
        merge = upd & keep;
    endfunction : merge

    // Byte lanes selected by wb_sel_i update in one edge; unselected lanes keep their fields.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_events_priority_q <= IPLR_RESET_VAL;
        end else if (access && req.we && aligned &&
                     index == IPLR_IDX_SYS) begin
            system_events_priority_q <= merge(system_events_priority_q,
                req.dat[15:0], lane_mask, IPLR_MASK_SYS);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_priority_a_q <= IPLR_RESET_VAL;
        end else if (access && req.we && aligned &&
                     index == IPLR_IDX_PA) begin
            periph_priority_a_q <= merge(periph_priority_a_q,
                req.dat[15:0], lane_mask, IPLR_MASK_PA);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_priority_b_q <= IPLR_RESET_VAL;
        end else if (access && req.we && aligned &&
                     index == IPLR_IDX_PB) begin
            periph_priority_b_q <= merge(periph_priority_b_q,
                req.dat[15:0], lane_mask, IPLR_MASK_PB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_priority_c_q <= IPLR_RESET_VAL;
        end else if (access && req.we && aligned &&
                     index == IPLR_IDX_PC) begin
            periph_priority_c_q <= merge(periph_priority_c_q,
                req.dat[15:0], lane_mask, IPLR_MASK_PC);
        end
    end

    always_comb begin
        rd_mux = 16'h0000;
        if (aligned) begin
            case (index)
                IPLR_IDX_SYS: begin
                    rd_mux = system_events_priority_q;
                end
                IPLR_IDX_PA: begin
                    rd_mux = periph_priority_a_q;
                end
                IPLR_IDX_PB: begin
                    rd_mux = periph_priority_b_q;
                end
                IPLR_IDX_PC: begin
                    rd_mux = periph_priority_c_q;
                end
                default: begin
                    rd_mux = 16'h0000;
                end
            endcase
        end
    end

    // Unmapped addresses are acknowledged, read zero and drop writes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (access && !req.we) begin
            rdata_q <= {16'h0000, rd_mux};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Source order: index k uses fields[2k+1:2k].
    assign fields = {
        system_events_priority_q[IPLR_POS_FLASH_ERR+:2],
        system_events_priority_q[IPLR_POS_PLL_UNLOCK+:2],
        system_events_priority_q[IPLR_POS_LOW_VOLT+:2],
        system_events_priority_q[IPLR_POS_EXT_B+:2],
        system_events_priority_q[IPLR_POS_EXT_A+:2],
        periph_priority_a_q[IPLR_POS_PORT_D+:2],
        periph_priority_a_q[IPLR_POS_PORT_E+:2],
        periph_priority_a_q[IPLR_POS_PORT_F+:2],
        periph_priority_a_q[IPLR_POS_CAN_MSGBUF+:2],
        periph_priority_a_q[IPLR_POS_CAN_WAKEUP+:2],
        periph_priority_a_q[IPLR_POS_CAN_ERROR+:2],
        periph_priority_a_q[IPLR_POS_CAN_BUSOFF+:2],
        periph_priority_b_q[IPLR_POS_SPI0_RX+:2],
        periph_priority_b_q[IPLR_POS_SPI1_TX+:2],
        periph_priority_b_q[IPLR_POS_SPI1_RX+:2],
        periph_priority_b_q[IPLR_POS_PORT_A+:2],
        periph_priority_b_q[IPLR_POS_PORT_B+:2],
        periph_priority_b_q[IPLR_POS_PORT_C+:2],
        periph_priority_c_q[IPLR_POS_DEC1_INDEX+:2],
        periph_priority_c_q[IPLR_POS_DEC1_HOME+:2],
        periph_priority_c_q[IPLR_POS_SER1_RX+:2],
        periph_priority_c_q[IPLR_POS_SER1_RXERR+:2],
        periph_priority_c_q[IPLR_POS_SER1_IDLE+:2],
        periph_priority_c_q[IPLR_POS_SER1_TX+:2],
        periph_priority_c_q[IPLR_POS_SPI0_TX+:2],
        2'h0, 2'h0, 2'h0
    };

    generate
        for (genvar k = 0; k < IPLR_NUM_SRC; k++) begin : g_src
            iplr_level_t lvl;
            iplr_decode u_dec (
                .field_i   (fields[2*k+:2]),
                .request_i (src_req_i[k]),
                .level_o   (lvl),
                .request_o (src_req_o[k])
            );
            assign src_enabled_o[k]     = lvl.enabled;
            assign src_level_o[2*k+:2]  = lvl.level;
        end
    endgenerate

endmodule : iplr_regs

// file: testbench/iplr_src_model.sv
module iplr_src_model
    import iplr_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic [IPLR_NUM_SRC-1:0] pattern_i,
    output logic      [IPLR_NUM_SRC-1:0] req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sources hold level requests in step with the system clock.
    always_ff @(posedge clk_i) begin
        req_o <= pattern_i;
    end
endmodule : iplr_src_model

// file: testbench/iplr_regs_chk.sv
module iplr_regs_chk
    import iplr_pkg::*;
(
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic [IPLR_ADDR_W-1:0]    wb_adr_i,
    input wire logic [31:0]               wb_dat_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic [IPLR_NUM_SRC-1:0]   src_req_i,
    input wire logic [IPLR_NUM_SRC-1:0]   src_req_o,
    input wire logic [IPLR_NUM_SRC-1:0]   src_enabled_o,
    input wire logic [2*IPLR_NUM_SRC-1:0] src_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lvl_bad;
    logic off_bad;
    always_comb begin
        lvl_bad = 1'b0;
        off_bad = 1'b0;
        for (int k = 0; k < IPLR_NUM_SRC; k++) begin
            lvl_bad = lvl_bad | (src_level_o[2*k+:2] == 2'h3);
            off_bad = off_bad | (!src_enabled_o[k] && |src_level_o[2*k+:2]);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence wr_s(a);
        take_s ##0 (wb_we_i && wb_adr_i == a);
    endsequence
    ack_answer_a: assert property (take_s |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    req_gate_a: assert property (src_req_o == (src_req_i & src_enabled_o))
        else $error("request gating wrong");
    level_off_a: assert property (!off_bad) else $error("level when off");
    level_max_a: assert property (!lvl_bad) else $error("level above 2");
    reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
        (src_enabled_o == '0 && !wb_ack_o)) else $error("reset not clear");
    dat_upper_a: assert property (wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    wr_sys_a: assert property (wr_s(6'h08) ##0 wb_sel_i[0] |=>
        src_enabled_o[23] == |$past(wb_dat_i[1:0])) else $error("ext a");
    wr_pa_a: assert property (wr_s(6'h0C) ##0 wb_sel_i[1] |=>
        src_enabled_o[22] == |$past(wb_dat_i[15:14])) else $error("port d");
endmodule : iplr_regs_chk

bind iplr_regs iplr_regs_chk chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_req_i(src_req_i), .src_req_o(src_req_o),
    .src_enabled_o(src_enabled_o), .src_level_o(src_level_o)
);

// file: testbench/iplr_regs_tb.sv
module iplr_regs_tb import iplr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [5:0]  adr;
        logic [15:0] wd;
        logic [15:0] rd;
    } iplr_row_t;
    logic         clk_i;
    logic         rst_i;
    iplr_wb_req_t req;
    logic [31:0]  dat_o;
    logic [31:0]  r;
    logic         ack;
    logic [27:0]  pat;
    logic [27:0]  req_i;
    logic [27:0]  req_o;
    logic [27:0]  en_o;
    logic [55:0]  lvl_o;
    int           n_mismatch = 0;
    int           checked = 0;
    iplr_row_t    rows [10] = '{'{6'h08, 16'hFFFF, 16'h0FCF},
        '{6'h0C, 16'hFFFF, 16'hFFFC}, '{6'h10, 16'hFFFF, 16'hFC3F},
        '{6'h14, 16'hFFFF, 16'hFF3F}, '{6'h08, 16'h5555, 16'h0545},
        '{6'h0C, 16'h5555, 16'h5554}, '{6'h10, 16'h5555, 16'h5415},
        '{6'h14, 16'h5555, 16'h5515}, '{6'h18, 16'hFFFF, 16'h0000},
        '{6'h09, 16'hFFFF, 16'h0000}};

    iplr_src_model src_u (.clk_i(clk_i), .pattern_i(pat), .req_o(req_i));
    iplr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc),
        .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
        .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .src_req_i(req_i), .src_req_o(req_o),
        .src_enabled_o(en_o), .src_level_o(lvl_o));

    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wb(input logic [5:0] a, input logic w, input logic [3:0] s,
                      input logic [15:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, s, a, {16'h0000, d}};
        // Ack and read data are taken only at a rising edge.
        @(posedge clk_i);
        for (int i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
        if (ack !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
        r = dat_o;
        req <= '0;
    endtask : wb

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        req = '0;
        pat = 28'hFFF_FFFF;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i].adr, 1'b1, 4'h3, rows[i].wd);
            wb(rows[i].adr, 1'b0, 4'h0, 16'h0000);
            cmp(r, {40'h0, rows[i].rd});
        end
        wb(6'h08, 1'b0, 4'h0, 16'h0000);
        cmp(r, 56'h545);
        wb(6'h08, 1'b1, 4'h3, 16'h0E43);
        cmp(lvl_o[55:46], 10'h242);
        cmp(en_o[27:23], 5'h1D);
        @(negedge clk_i);
        cmp(req_o[27:23], 5'h1D);
        wb(6'h0C, 1'b1, 4'h2, 16'hFFFF);
        wb(6'h0C, 1'b0, 4'h0, 16'h0000);
        cmp(r, 56'h0_FF54);
        wb(6'h0C, 1'b1, 4'h3, 16'h1B1B);
        wb(6'h10, 1'b1, 4'h3, 16'h1B1B);
        wb(6'h14, 1'b1, 4'h3, 16'h1B1B);
        cmp(lvl_o[45:32], 14'h0181);
        cmp(lvl_o[31:20], 12'h046);
        cmp(lvl_o[19:6], 14'h0186);
        cmp(en_o, 28'hEBB_7DF8);
        @(posedge clk_i);
        pat <= 28'h555_5555;
        @(posedge clk_i);
        @(negedge clk_i);
        cmp(req_o, 28'h411_5550);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(6'h14, 1'b0, 4'h0, 16'h0000);
        cmp(r, 56'h0);
        cmp(en_o, 56'h0);
        finish_test();
    end
endmodule : iplr_regs_tb
